// ===== pkg/gdc_pkg.sv
// package: register map, field layout and reset values of the gate driver config bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package gdc_pkg;

  localparam int unsigned GDC_AW = 4;
  localparam int unsigned GDC_DW = 8;

  // ----------------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------------
  localparam logic [GDC_AW-1:0] GDC_ADDR_OC_THR  = 4'ha;
  localparam logic [GDC_AW-1:0] GDC_ADDR_DIAG    = 4'hb;
  localparam logic [GDC_AW-1:0] GDC_ADDR_SUPPLY  = 4'hc;
  localparam logic [GDC_AW-1:0] GDC_ADDR_AMP     = 4'hd;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [GDC_DW-1:0] GDC_RST_OC_THR = 8'hdd;
  localparam logic [GDC_DW-1:0] GDC_RST_DIAG   = 8'h00;
  localparam logic [GDC_DW-1:0] GDC_RST_SUPPLY = 8'h14;
  localparam logic [GDC_DW-1:0] GDC_RST_AMP    = 8'h01;

  // ----------------------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] high_side_oc_threshold;
    logic [3:0] low_side_oc_threshold;
  } gdc_oc_thr_s;

  typedef struct packed {
    logic [2:0] reserved;
    logic       offline_diag_enable;
    logic       bridge1_pullup_source_en;
    logic       bridge1_pulldown_source_en;
    logic       bridge2_pullup_source_en;
    logic       bridge2_pulldown_source_en;
  } gdc_diag_s;

  typedef enum logic [1:0] {
    GDC_OV_LATCH   = 2'h0,
    GDC_OV_RECOVER = 2'h1,
    GDC_OV_WARN    = 2'h2,
    GDC_OV_OFF     = 2'h3
  } gdc_ov_resp_e;

  typedef struct packed {
    logic         supply_undervoltage_response;
    gdc_ov_resp_e supply_overvoltage_response;
    logic [1:0]   supply_overvoltage_deglitch;
    logic         supply_overvoltage_threshold;
    logic         pump_undervoltage_response;
    logic         pump_undervoltage_threshold;
  } gdc_supply_s;

  typedef struct packed {
    logic       amp_sample_hold_enable;
    logic       amp_blanking_source;
    logic [2:0] amp_blanking_time;
    logic       amp_reference_divider;
    logic [1:0] amp_gain_select;
  } gdc_amp_s;

  // host register port
  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [GDC_AW-1:0] addr;
    logic [GDC_DW-1:0] wdata;
  } gdc_req_s;

  typedef struct packed {
    logic              rvalid;
    logic [GDC_DW-1:0] rdata;
  } gdc_rsp_s;

  // decoded settings for comparators and sources
  typedef struct packed {
    logic [3:0]   high_side_oc_threshold;
    logic [3:0]   low_side_oc_threshold;
    logic         realtime_vds_monitor;
    logic [3:0]   diag_source_on;
    logic         supply_uv_auto_recover;
    gdc_ov_resp_e supply_ov_response;
    logic [1:0]   supply_ov_deglitch;
    logic         supply_ov_high_threshold;
    logic         pump_uv_auto_recover;
    logic         pump_uv_high_threshold;
    gdc_amp_s     amp;
  } gdc_cfg_s;

  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    gdc_oc_thr_s oc_thr;
    gdc_diag_s   diag;
    gdc_supply_s supply;
    gdc_amp_s    amp;
    gdc_rsp_s    rsp;
    gdc_cfg_s    cfg;
  } gdc_state_s;

endpackage : gdc_pkg

// ===== logic/gdc_regs.sv
// module: gate driver monitor configuration register bank
`timescale 1ns/1ps
`default_nettype none

module gdc_regs
  import gdc_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire logic     clk_en,
  input  wire gdc_req_s req,
  output var  gdc_rsp_s rsp,
  output var  gdc_cfg_s cfg
);

  // ----------------------------------------------------------------------------
  // reset release through two flip-flops
  // ----------------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  gdc_oc_thr_s oc_q,  oc_d;
  gdc_diag_s   dg_q,  dg_d;
  gdc_supply_s sp_q,  sp_d;
  gdc_amp_s    am_q,  am_d;
  gdc_rsp_s    rsp_q, rsp_d;
  gdc_cfg_s    cfg_q, cfg_d;

  localparam gdc_oc_thr_s RST_OC = gdc_oc_thr_s'(GDC_RST_OC_THR);
  localparam gdc_supply_s RST_SP = gdc_supply_s'(GDC_RST_SUPPLY);

  always_comb begin
    oc_d  = oc_q;
    dg_d  = dg_q;
    sp_d  = sp_q;
    am_d  = am_q;
    rsp_d = '0;
    if (req.wr_en) begin
      unique case (req.addr)
        GDC_ADDR_OC_THR: oc_d = gdc_oc_thr_s'(req.wdata);
        GDC_ADDR_DIAG:   dg_d = gdc_diag_s'(req.wdata);
        GDC_ADDR_SUPPLY: sp_d = gdc_supply_s'(req.wdata);
        GDC_ADDR_AMP:    am_d = gdc_amp_s'(req.wdata);
        default: ;
      endcase
    end
    if (req.rd_en) begin
      rsp_d.rvalid = 1'b1;
      unique case (req.addr)
        GDC_ADDR_OC_THR: rsp_d.rdata = oc_q;
        GDC_ADDR_DIAG:   rsp_d.rdata = dg_q;
        GDC_ADDR_SUPPLY: rsp_d.rdata = sp_q;
        GDC_ADDR_AMP:    rsp_d.rdata = am_q;
        default:         rsp_d.rdata = '0;
      endcase
    end
    // decoded outputs follow the stored fields of the next cycle
    cfg_d.high_side_oc_threshold   = oc_d.high_side_oc_threshold;
    cfg_d.low_side_oc_threshold    = oc_d.low_side_oc_threshold;
    cfg_d.realtime_vds_monitor     = dg_d.offline_diag_enable;
    cfg_d.diag_source_on[3] = dg_d.offline_diag_enable & dg_d.bridge1_pullup_source_en;
    cfg_d.diag_source_on[2] = dg_d.offline_diag_enable & dg_d.bridge1_pulldown_source_en;
    cfg_d.diag_source_on[1] = dg_d.offline_diag_enable & dg_d.bridge2_pullup_source_en;
    cfg_d.diag_source_on[0] = dg_d.offline_diag_enable & dg_d.bridge2_pulldown_source_en;
    cfg_d.supply_uv_auto_recover   = sp_d.supply_undervoltage_response;
    cfg_d.supply_ov_response       = sp_d.supply_overvoltage_response;
    cfg_d.supply_ov_deglitch       = sp_d.supply_overvoltage_deglitch;
    cfg_d.supply_ov_high_threshold = sp_d.supply_overvoltage_threshold;
    cfg_d.pump_uv_auto_recover     = sp_d.pump_undervoltage_response;
    cfg_d.pump_uv_high_threshold   = sp_d.pump_undervoltage_threshold;
    cfg_d.amp                      = am_d;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oc_q  <= gdc_oc_thr_s'(GDC_RST_OC_THR);
      dg_q  <= gdc_diag_s'(GDC_RST_DIAG);
      sp_q  <= gdc_supply_s'(GDC_RST_SUPPLY);
      am_q  <= gdc_amp_s'(GDC_RST_AMP);
      rsp_q <= '0;
      cfg_q <= '{high_side_oc_threshold:   RST_OC.high_side_oc_threshold,
                 low_side_oc_threshold:    RST_OC.low_side_oc_threshold,
                 supply_uv_auto_recover:   RST_SP.supply_undervoltage_response,
                 supply_ov_response:       RST_SP.supply_overvoltage_response,
                 supply_ov_deglitch:       RST_SP.supply_overvoltage_deglitch,
                 supply_ov_high_threshold: RST_SP.supply_overvoltage_threshold,
                 pump_uv_auto_recover:     RST_SP.pump_undervoltage_response,
                 pump_uv_high_threshold:   RST_SP.pump_undervoltage_threshold,
                 amp:                      gdc_amp_s'(GDC_RST_AMP),
                 default:                  '0};
    end else if (clk_en) begin
      oc_q  <= oc_d;
      dg_q  <= dg_d;
      sp_q  <= sp_d;
      am_q  <= am_d;
      rsp_q <= rsp_d;
      cfg_q <= cfg_d;
    end
  end

  assign rsp = rsp_q;
  assign cfg = cfg_q;

endmodule : gdc_regs

`default_nettype wire

// ===== verif/gdc_host.sv
// host model: issues register requests on falling edges
`timescale 1ns/1ps
`default_nettype none
module gdc_host
  import gdc_pkg::*;
(
  input  wire logic     sys_clk,
  output var  gdc_req_s req
);
  initial req = '0;
  // one request cycle, then release
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(negedge sys_clk);
    req = '0;
  endtask : xfer
endmodule : gdc_host
`default_nettype wire

// ===== verif/gdc_regs_sva.sv
// checker: port assertions of the config register bank
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_sva
  import gdc_pkg::*;
(
  input wire logic     sys_clk,
  input wire logic     rst_n,
  input wire logic     clk_en,
  input wire gdc_req_s req,
  input wire gdc_rsp_s rsp,
  input wire gdc_cfg_s cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic rd;
  assign wr = clk_en && req.wr_en;
  assign rd = clk_en && req.rd_en;
  a_read_answer: assert property (rd |=> rsp.rvalid) else $error("no read answer");
  a_no_stray: assert property (clk_en && !req.rd_en |=> !rsp.rvalid && rsp.rdata == 8'h00)
    else $error("stray answer");
  a_oc_write: assert property (wr && req.addr == GDC_ADDR_OC_THR |=>
    cfg[28:21] == $past(req.wdata)) else $error("threshold write");
  a_diag_gate: assert property (wr && req.addr == GDC_ADDR_DIAG |=>
    cfg[20:16] == {$past(req.wdata[4]), $past(req.wdata[3:0]) & {4{$past(req.wdata[4])}}})
    else $error("diag gating");
  a_supply_write: assert property (wr && req.addr == GDC_ADDR_SUPPLY |=>
    cfg[15:8] == $past(req.wdata)) else $error("supply write");
  a_amp_write: assert property (wr && req.addr == GDC_ADDR_AMP |=>
    cfg.amp == $past(req.wdata)) else $error("amp write");
  a_cfg_hold: assert property (!wr |=> $stable(cfg)) else $error("cfg moved");
  a_oc_read: assert property (rd && req.addr == GDC_ADDR_OC_THR |=>
    rsp.rdata == $past(cfg[28:21])) else $error("threshold read");
  a_unmapped_read: assert property (rd && (req.addr < 4'ha || req.addr > 4'hd) |=>
    rsp.rdata == 8'h00) else $error("unmapped read");
  c_diag_on: cover property (wr && req.addr == GDC_ADDR_DIAG && req.wdata[4]);
  c_read: cover property (rd ##1 rsp.rvalid);
  c_frozen: cover property (!clk_en && req.wr_en);
endmodule : gdc_regs_sva
bind gdc_regs gdc_regs_sva gdc_regs_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .req(req), .rsp(rsp), .cfg(cfg));
`default_nettype wire

// ===== verif/gdc_regs_tb_top.sv
// testbench: config register bank against its register table
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_tb_top
  import gdc_pkg::*;
;
  logic       sys_clk  = 1'b0;
  logic       rst_n    = 1'b0;
  logic       clk_en   = 1'b1;
  gdc_req_s   req;
  gdc_rsp_s   rsp;
  gdc_cfg_s   cfg;
  int         n_fail   = 0;
  int         compares = 0;
  integer     seed     = 93;
  logic [7:0] mdl [4];
  logic [3:0] a;
  always #5 sys_clk = ~sys_clk;
  gdc_host gdc_host_i (.sys_clk(sys_clk), .req(req));
  gdc_regs gdc_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .rsp(rsp), .cfg(cfg));
  function automatic gdc_cfg_s exp_cfg();
    return {mdl[0], mdl[1][4], mdl[1][3:0] & {4{mdl[1][4]}}, mdl[2], mdl[3]};
  endfunction : exp_cfg
  task automatic chk(string nm, logic [28:0] seen, logic [28:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic rst_all();
    mdl = '{8'hdd, 8'h00, 8'h14, 8'h01};
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask : rst_all
  task automatic wr(logic [3:0] ad, logic [7:0] d);
    gdc_host_i.xfer(1'b1, ad, d);
    if (clk_en && ad >= 4'ha && ad <= 4'hd) mdl[ad-4'ha] = d;
  endtask : wr
  task automatic rd_chk(logic [3:0] ad);
    logic [7:0] e;
    e = (ad >= 4'ha && ad <= 4'hd) ? mdl[ad-4'ha] : 8'h00;
    gdc_host_i.xfer(1'b0, ad, 8'h00);
    chk("rdata", {20'h0, rsp.rvalid, rsp.rdata}, {20'h0, 1'b1, e});
  endtask : rd_chk
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_all();
    for (int i = 8; i < 16; i++) rd_chk(i[3:0]);
    chk("cfg", cfg, exp_cfg());
    wr(GDC_ADDR_DIAG, 8'h0f);
    chk("cfg", cfg, exp_cfg());
    wr(GDC_ADDR_DIAG, 8'hff);
    chk("cfg", cfg, exp_cfg());
    rd_chk(GDC_ADDR_DIAG);
    clk_en = 1'b0;
    wr(GDC_ADDR_OC_THR, 8'h00);
    clk_en = 1'b1;
    rd_chk(GDC_ADDR_OC_THR);
    for (int g = 0; g < 4; g++) begin
      wr(GDC_ADDR_AMP, {6'h2a, g[1:0]});
      chk("cfg", cfg, exp_cfg());
    end
    repeat (60) begin
      a = 4'h8 + 4'($unsigned($random(seed)) % 8);
      wr(a, 8'($random(seed)));
      rd_chk(a);
      chk("cfg", cfg, exp_cfg());
    end
    rst_all();
    chk("cfg", cfg, exp_cfg());
    give_verdict();
  end
endmodule : gdc_regs_tb_top
`default_nettype wire
